// ---- rtl/acs_pkg.sv ----
// acs_pkg: constants and types of the converter channel sequencer
package acs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ACS_DATA_W = 12;
  localparam int ACS_RES_W  = 12;
  localparam int ACS_CH_W   = 3;
  localparam int ACS_NUM_CH = 8;
  localparam int ACS_NPINS  = 4;

  // ---------------------------------------------------------------
  // control word field positions
  // ---------------------------------------------------------------
  localparam int ACS_BIT_CODING   = 0;
  localparam int ACS_BIT_RANGE    = 1;
  localparam int ACS_BIT_MASK_SEL = 2;
  localparam int ACS_BIT_SEQ_EN   = 3;
  localparam int ACS_FLD_INMODE   = 4;
  localparam int ACS_FLD_ADDR     = 6;
  localparam int ACS_FLD_PM       = 9;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [ACS_NUM_CH-1:0] ACS_MASK_RESET   = 8'h00;
  localparam logic [ACS_NUM_CH-1:0] ACS_PAIR_MASK    = 8'h55;
  localparam logic [ACS_NUM_CH-1:0] ACS_PSEUDO2_MASK = 8'h7f;
  localparam logic [ACS_NUM_CH-1:0] ACS_ALL_MASK     = 8'hff;
  localparam logic [ACS_CH_W-1:0]   ACS_CH_RESET     = 3'h0;
  localparam logic [ACS_CH_W-1:0]   ACS_COMMON_CH    = 3'h7;
  localparam logic [ACS_DATA_W-1:0] ACS_DATA_RESET   = 12'h000;
  localparam logic [ACS_RES_W-1:0]  ACS_SAR_MSB      = 12'h800;
  localparam logic [ACS_RES_W-1:0]  ACS_RES_RESET    = 12'h000;
  // wr_n high, start high, converter clock low, comparator low
  localparam logic [ACS_NPINS-1:0]  ACS_PIN_IDLE     = 4'h3;

  // pin synchroniser lanes
  localparam int ACS_PIN_WR    = 0;
  localparam int ACS_PIN_START = 1;
  localparam int ACS_PIN_CLK   = 2;
  localparam int ACS_PIN_CMP   = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [3:0] ACS_CONV_PERIODS = 4'hd;
  localparam logic [3:0] ACS_CONV_LAST    = ACS_CONV_PERIODS - 4'h1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACS_IN_SINGLE  = 2'h0,
    ACS_IN_FULLDIF = 2'h1,
    ACS_IN_PSEUDO1 = 2'h2,
    ACS_IN_PSEUDO2 = 2'h3
  } acs_inmode_t;

  typedef enum logic [1:0] {
    ACS_PM_NORMAL   = 2'h0,
    ACS_PM_AUTOSHDN = 2'h1,
    ACS_PM_AUTOSTBY = 2'h2,
    ACS_PM_FULLSHDN = 2'h3
  } acs_pm_t;

  typedef enum logic [3:0] {
    ACS_ST_SINGLE  = 4'b0001,
    ACS_ST_AWAIT   = 4'b0010,
    ACS_ST_MASKRUN = 4'b0100,
    ACS_ST_CONSEC  = 4'b1000
  } acs_seq_t;

endpackage

// ---- rtl/acs_sar_if.sv ----
// acs_sar_if: link between sequencer control and approximation engine
`timescale 1ns/100ps
`default_nettype none
interface acs_sar_if;
  logic        start;
  logic        clk_fall;
  logic        comparator;
  logic        busy;
  logic        done;
  logic [11:0] code;
  logic [11:0] result;

  modport ctl (output start, output clk_fall, output comparator,
               input busy, input done, input code, input result);
  modport eng (input start, input clk_fall, input comparator,
               output busy, output done, output code, output result);
endinterface
`default_nettype wire

// ---- rtl/acs_sar.sv ----
// acs_sar: successive approximation engine paced by the converter clock
`timescale 1ns/100ps
`default_nettype none
module acs_sar
  import acs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  acs_sar_if.eng    sar
);

  logic [3:0]           count;
  logic [ACS_RES_W-1:0] code;
  logic [ACS_RES_W-1:0] result;
  logic                 busy;
  logic                 done;

  // ---------------------------------------------------------------
  // bit trial
  // ---------------------------------------------------------------
  wire [ACS_RES_W-1:0] trial_bit = ACS_SAR_MSB >> count;
  wire [ACS_RES_W-1:0] next_bit  = trial_bit >> 1;
  wire [ACS_RES_W-1:0] decided   = sar.comparator ? code
                                                  : (code & ~trial_bit);
  wire [ACS_RES_W-1:0] next_code = decided | next_bit;
  wire                 last      = (count == ACS_CONV_LAST);

  // a new start restarts at once; the host sees it as an abort
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      busy   <= 1'b0;
      done   <= 1'b0;
      count  <= 4'h0;
      code   <= ACS_RES_RESET;
      result <= ACS_RES_RESET;
    end
    else
    begin
      done <= 1'b0;
      if (sar.start)
      begin
        busy  <= 1'b1;
        count <= 4'h0;
        code  <= ACS_SAR_MSB;
      end
      else if (busy && sar.clk_fall)
      begin
        if (last)
        begin
          busy   <= 1'b0; // R17
          done   <= 1'b1;
          result <= code; // R12
        end
        else
        begin
          code  <= next_code; // R12
          count <= count + 4'h1; // R17
        end
      end
    end
  end

  assign sar.busy   = busy;
  assign sar.done   = done;
  assign sar.code   = code;
  assign sar.result = result;

endmodule
`default_nettype wire

// ---- rtl/acs_top.sv ----
// acs_top: channel sequencer and control of the 8-channel converter
//
// Contract
// R1: sequencer off: convert channel of latest write
// R2: mask-select write makes next write the mask
// R3: programmed mask stepped on each start fall
// R4: sequence-keep write changes only other bits
// R5: both bits set: channels zero to address
// R6: mask bit n enables channel n
// R7: advance one selected channel per start
// R8: four input configurations of the eight inputs
// R9: span bit picks reference or double span
// R10: coding bit picks binary or twos complement
// R11: two-bit field selects power behaviour
// R12: twelve-bit result, lsb is reference/4096
// R13: hold inputs disconnected through whole conversion
// R14: ascending order from lowest selected channel
// R15: sequence runs until non keep write
// R16: differential modes skip swapped pairs
// R17: thirteen clock periods, fewer aborts
// R18: after last channel wrap to first
`timescale 1ns/100ps
`default_nettype none
module acs_top
  import acs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  wr_n,
  input  wire logic [ACS_DATA_W-1:0] data_bus,
  input  wire logic                  conversion_start_n,
  input  wire logic                  converter_clock_input,
  input  wire logic                  comparator_in,
  output var  logic [ACS_CH_W-1:0]   vin_plus_sel,
  output var  logic [ACS_CH_W-1:0]   vin_minus_sel,
  output var  logic                  vin_minus_gnd,
  output var  logic                  span_double,
  output var  logic                  twos_complement,
  output var  logic [1:0]            power_mode,
  output var  logic                  power_down,
  output var  logic                  track_hold,
  output var  logic [ACS_RES_W-1:0]  dac_code,
  output var  logic [ACS_RES_W-1:0]  conv_result,
  output var  logic                  conv_done,
  output var  logic                  conv_aborted
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [ACS_NPINS-1:0]  s1;
  logic [ACS_NPINS-1:0]  s2;
  logic [ACS_NPINS-1:0]  s3;
  logic [ACS_NPINS-1:0]  lvl;
  logic [ACS_NPINS-1:0]  lvl_d;
  logic [ACS_NPINS-1:0]  next_lvl;
  logic [ACS_DATA_W-1:0] d1;
  logic [ACS_DATA_W-1:0] d2;
  logic [ACS_DATA_W-1:0] d3;

  wire [ACS_NPINS-1:0] pins = {comparator_in, converter_clock_input,
                               conversion_start_n, wr_n};

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s1    <= ACS_PIN_IDLE;
      s2    <= ACS_PIN_IDLE;
      s3    <= ACS_PIN_IDLE;
      lvl   <= ACS_PIN_IDLE;
      lvl_d <= ACS_PIN_IDLE;
      d1    <= ACS_DATA_RESET;
      d2    <= ACS_DATA_RESET;
      d3    <= ACS_DATA_RESET;
    end
    else
    begin
      s1    <= pins;
      s2    <= s1;
      s3    <= s2;
      lvl   <= next_lvl;
      lvl_d <= lvl;
      d1    <= data_bus;
      d2    <= d1;
      d3    <= d2;
    end
  end

  // a level only counts once two later stages agree: filters glitches
  genvar p;
  generate
    for (p = 0; p < ACS_NPINS; p++)
    begin : g_pin
      assign next_lvl[p] = (s2[p] == s3[p]) ? s3[p] : lvl[p];
    end
  endgenerate

  wire wr_rise    = lvl[ACS_PIN_WR] & ~lvl_d[ACS_PIN_WR];
  wire start_fall = ~lvl[ACS_PIN_START] & lvl_d[ACS_PIN_START];
  wire clk_fall   = ~lvl[ACS_PIN_CLK] & lvl_d[ACS_PIN_CLK];

  // ---------------------------------------------------------------
  // control word decode
  // ---------------------------------------------------------------
  acs_seq_t              state;
  acs_seq_t              next_state;
  acs_inmode_t           inmode;
  logic [ACS_CH_W-1:0]   addr;
  logic [ACS_NUM_CH-1:0] run_mask;
  logic [ACS_CH_W-1:0]   cur_ch;
  logic                  fresh;
  logic                  sar_start;

  wire                 w_seq    = d3[ACS_BIT_SEQ_EN];
  wire                 w_mask_select_bit   = d3[ACS_BIT_MASK_SEL];
  wire [ACS_CH_W-1:0]  w_addr   = d3[ACS_FLD_ADDR +: ACS_CH_W];
  wire [1:0]           w_inmode = d3[ACS_FLD_INMODE +: 2];
  wire [1:0]           w_pm     = d3[ACS_FLD_PM +: 2];
  wire                 mask_wr  = wr_rise && (state == ACS_ST_AWAIT);
  wire                 ctrl_wr  = wr_rise && (state != ACS_ST_AWAIT);
  wire                 run      = (state == ACS_ST_MASKRUN) ||
                                  (state == ACS_ST_CONSEC);

  always_comb
  begin
    next_state = state;
    if (mask_wr)
      next_state = ACS_ST_MASKRUN; // R2
    else if (ctrl_wr)
    begin
      case ({w_seq, w_mask_select_bit})
        2'b00:   next_state = ACS_ST_SINGLE; // R1 R15
        2'b01:   next_state = ACS_ST_AWAIT; // R2 R15
        2'b10:   next_state = state; // R4
        2'b11:   next_state = ACS_ST_CONSEC; // R5 R15
        default: next_state = state;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // channel selection
  // ---------------------------------------------------------------
  function automatic logic [ACS_CH_W-1:0] acs_lowest
    (input logic [ACS_NUM_CH-1:0] v);
    logic [ACS_CH_W-1:0] r;
    r = ACS_CH_RESET;
    for (int k = ACS_NUM_CH - 1; k >= 0; k--)
      if (v[k])
        r = ACS_CH_W'(k);
    return r;
  endfunction

  logic [ACS_NUM_CH-1:0] above;
  logic [ACS_NUM_CH-1:0] consec_mask;

  wire [ACS_NUM_CH-1:0] mode_mask =
    (inmode == ACS_IN_FULLDIF || inmode == ACS_IN_PSEUDO1) ? ACS_PAIR_MASK
    : (inmode == ACS_IN_PSEUDO2) ? ACS_PSEUDO2_MASK : ACS_ALL_MASK; // R16
  wire [ACS_NUM_CH-1:0] elig = run_mask & mode_mask; // R16

  genvar i;
  generate
    for (i = 0; i < ACS_NUM_CH; i++)
    begin : g_ch
      localparam logic [ACS_CH_W-1:0] IDX = ACS_CH_W'(i);
      assign above[i]       = elig[i] && (IDX > cur_ch); // R14
      assign consec_mask[i] = (IDX <= w_addr); // R5
    end
  endgenerate

  wire [ACS_CH_W-1:0] first_ch = acs_lowest(elig); // R14
  wire [ACS_CH_W-1:0] above_ch = acs_lowest(above); // R7
  // past the last selected channel the search falls back to the first
  wire [ACS_CH_W-1:0] seq_ch   = (fresh || ~|above) ? first_ch
                                                    : above_ch; // R18
  wire [ACS_CH_W-1:0] pick_ch  = !run ? addr // R1
                                 : (~|elig) ? cur_ch : seq_ch; // R3
  wire                start_go = start_fall &&
                                 (power_mode != ACS_PM_FULLSHDN);

  // ---------------------------------------------------------------
  // input routing
  // ---------------------------------------------------------------
  wire [ACS_CH_W-1:0] pick_minus =
    (inmode == ACS_IN_PSEUDO2) ? ACS_COMMON_CH
    : (inmode == ACS_IN_SINGLE) ? ACS_CH_RESET
    : (pick_ch ^ 3'h1); // R8
  wire                pick_gnd   = (inmode == ACS_IN_SINGLE); // R8

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state           <= ACS_ST_SINGLE;
      inmode          <= ACS_IN_SINGLE;
      addr            <= ACS_CH_RESET;
      run_mask        <= ACS_MASK_RESET;
      cur_ch          <= ACS_CH_RESET;
      fresh           <= 1'b1;
      span_double     <= 1'b0;
      twos_complement <= 1'b0;
      power_mode      <= ACS_PM_NORMAL;
    end
    else
    begin
      state <= next_state;
      if (mask_wr)
      begin
        run_mask <= d3[ACS_NUM_CH-1:0]; // R6
        fresh    <= 1'b1; // R14
      end
      else if (ctrl_wr)
      begin
        addr            <= w_addr;
        inmode          <= acs_inmode_t'(w_inmode); // R8
        span_double     <= d3[ACS_BIT_RANGE]; // R9
        twos_complement <= d3[ACS_BIT_CODING]; // R10
        power_mode      <= w_pm; // R11
        if (w_seq && w_mask_select_bit)
        begin
          run_mask <= consec_mask; // R5
          fresh    <= 1'b1;
        end
      end
      else if (start_go)
      begin
        cur_ch <= pick_ch; // R3 R7
        fresh  <= fresh && !run;
      end
    end
  end

  // ---------------------------------------------------------------
  // conversion control
  // ---------------------------------------------------------------
  acs_sar_if sar_bus ();

  assign sar_bus.start      = sar_start;
  assign sar_bus.clk_fall   = clk_fall;
  assign sar_bus.comparator = lvl[ACS_PIN_CMP];

  acs_sar u_sar (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sar      (sar_bus)
  );

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sar_start     <= 1'b0;
      track_hold    <= 1'b0;
      vin_plus_sel  <= ACS_CH_RESET;
      vin_minus_sel <= ACS_CH_RESET;
      vin_minus_gnd <= 1'b1;
      conv_aborted  <= 1'b0;
      conv_done     <= 1'b0;
      conv_result   <= ACS_RES_RESET;
      dac_code      <= ACS_RES_RESET;
      power_down    <= 1'b0;
    end
    else
    begin
      sar_start    <= start_go;
      conv_aborted <= start_go && sar_bus.busy; // R17
      conv_done    <= sar_bus.done;
      dac_code     <= sar_bus.code;
      if (start_go)
      begin
        track_hold    <= 1'b1; // R13
        vin_plus_sel  <= pick_ch; // R8
        vin_minus_sel <= pick_minus;
        vin_minus_gnd <= pick_gnd;
      end
      else if (sar_bus.done)
        track_hold <= 1'b0; // R13
      if (sar_bus.done)
        conv_result <= twos_complement ? (sar_bus.result ^ ACS_SAR_MSB)
                                       : sar_bus.result; // R10 R12
      // auto modes power down only while no conversion is held
      power_down <= (power_mode == ACS_PM_FULLSHDN) ||
                    ((power_mode != ACS_PM_NORMAL) &&
                     !track_hold && !start_go); // R11
    end
  end

endmodule
`default_nettype wire

// ---- dv/acs_top_asserts.sv ----
// acs_top_asserts: port-level checker of the channel sequencer
`timescale 1ns/100ps
`default_nettype none
module acs_chk
  import acs_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic                 track_hold,
  input wire logic [ACS_RES_W-1:0] dac_code,
  input wire logic [ACS_RES_W-1:0] conv_result,
  input wire logic                 conv_done,
  input wire logic                 conv_aborted,
  input wire logic [ACS_CH_W-1:0]  vin_plus_sel,
  input wire logic [ACS_CH_W-1:0]  vin_minus_sel,
  input wire logic                 vin_minus_gnd,
  input wire logic [1:0]           power_mode,
  input wire logic                 power_down
);
  // ---------------------------------------------------------------
  // conversion steps
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_msb_trial;
    ##[1:3] (dac_code == ACS_SAR_MSB);
  endsequence
  sequence s_hold_drop;
    $past(track_hold) && !track_hold;
  endsequence

  a_msb_first: assert property ($rose(track_hold) |-> s_msb_trial)
    else $error("first trial code is not the msb");
  a_done_release: assert property (conv_done |-> s_hold_drop)
    else $error("hold not released with done");
  a_done_pulse: assert property (conv_done |=> !conv_done)
    else $error("done longer than one cycle");
  a_abort_pulse: assert property (conv_aborted |=> !conv_aborted)
    else $error("abort longer than one cycle");
  a_result_held: assert property ($changed(conv_result) |-> conv_done)
    else $error("result changed without done");
  a_sel_hold: assert property ($changed(vin_plus_sel) |-> track_hold)
    else $error("channel changed outside a conversion");
  a_single_gnd: assert property (vin_minus_gnd |-> vin_minus_sel == 3'h0)
    else $error("single ended minus select not zero");
  a_pair_minus: assert property (!vin_minus_gnd |->
    vin_minus_sel == (vin_plus_sel ^ 3'h1) || vin_minus_sel == ACS_COMMON_CH)
    else $error("minus select not partner or common");
  // power_down is registered from power_mode, so it trails by one cycle
  a_full_shdn: assert property ($past(power_mode) == 2'h3 |-> power_down)
    else $error("full shutdown not powered down");
  a_normal_up: assert property ($past(power_mode) == 2'h0 |-> !power_down)
    else $error("normal mode powered down");
endmodule

bind acs_top acs_chk acs_chk_inst (
  .core_clk(core_clk), .resetn(resetn), .track_hold(track_hold),
  .dac_code(dac_code), .conv_result(conv_result), .conv_done(conv_done),
  .conv_aborted(conv_aborted), .vin_plus_sel(vin_plus_sel),
  .vin_minus_sel(vin_minus_sel), .vin_minus_gnd(vin_minus_gnd),
  .power_mode(power_mode), .power_down(power_down)
);
`default_nettype wire

// ---- dv/acs_host.sv ----
// acs_host: host processor and analog source facing the converter pins
`timescale 1ns/100ps
`default_nettype none
module acs_host
  import acs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic [ACS_RES_W-1:0]  dac_code,
  output var  logic                  wr_n,
  output var  logic [ACS_DATA_W-1:0] data_bus,
  output var  logic                  conversion_start_n,
  output var  logic                  converter_clock_input,
  output var  logic                  comparator_in
);
  logic [ACS_RES_W-1:0] analog;

  initial
  begin
    wr_n = 1'b1;
    data_bus = 12'h000;
    conversion_start_n = 1'b1;
    converter_clock_input = 1'b0;
    analog = 12'h000;
  end

  always_comb comparator_in = (analog >= dac_code);

  // ---------------------------------------------------------------
  // bus write; data held well around the strobe rise, then scrambled
  // ---------------------------------------------------------------
  task automatic write_word(input logic [ACS_DATA_W-1:0] w);
    @(negedge core_clk);
    data_bus = w;
    repeat (4) @(negedge core_clk);
    wr_n = 1'b0;
    repeat (4) @(negedge core_clk);
    wr_n = 1'b1;
    repeat (5) @(negedge core_clk);
    data_bus = ~w;
    repeat (4) @(negedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // start pulse then a given count of converter clock periods
  // ---------------------------------------------------------------
  // the clock idles low between frames, so a short count aborts
  task automatic convert(input int falls, input logic [ACS_RES_W-1:0] v);
    @(negedge core_clk);
    analog = v;
    conversion_start_n = 1'b0;
    repeat (4) @(negedge core_clk);
    conversion_start_n = 1'b1;
    repeat (falls)
    begin
      repeat (10) @(negedge core_clk);
      converter_clock_input = 1'b1;
      repeat (10) @(negedge core_clk);
      converter_clock_input = 1'b0;
    end
    repeat (8) @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_adc_channel_sequencer.sv ----
// tb_adc_channel_sequencer: self-checking bench of the channel sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_adc_channel_sequencer
  import acs_pkg::*;
;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  wire logic wr_n, conversion_start_n, converter_clock_input, comparator_in;
  wire logic [ACS_DATA_W-1:0] data_bus;
  wire logic [ACS_CH_W-1:0] vin_plus_sel, vin_minus_sel;
  wire logic vin_minus_gnd, span_double, twos_complement, power_down;
  wire logic track_hold, conv_done, conv_aborted;
  wire logic [1:0] power_mode;
  wire logic [ACS_RES_W-1:0] dac_code, conv_result;
  int n_mismatch = 0;
  int checks = 0;
  int n_abort = 0;
  int cur = 7;
  logic tc = 1'b0;
  logic [31:0] rng = 32'h679e3477;
  logic [15:0] exp_q[$];

  always #2.5 core_clk = ~core_clk;

  acs_host acs_host_inst (.core_clk(core_clk), .dac_code(dac_code),
    .wr_n(wr_n), .data_bus(data_bus), .conversion_start_n(conversion_start_n),
    .converter_clock_input(converter_clock_input),
    .comparator_in(comparator_in));

  acs_top acs_top_inst (.core_clk(core_clk), .resetn(resetn), .wr_n(wr_n),
    .data_bus(data_bus), .conversion_start_n(conversion_start_n),
    .converter_clock_input(converter_clock_input),
    .comparator_in(comparator_in), .vin_plus_sel(vin_plus_sel),
    .vin_minus_sel(vin_minus_sel), .vin_minus_gnd(vin_minus_gnd),
    .span_double(span_double), .twos_complement(twos_complement),
    .power_mode(power_mode), .power_down(power_down),
    .track_hold(track_hold), .dac_code(dac_code),
    .conv_result(conv_result), .conv_done(conv_done),
    .conv_aborted(conv_aborted));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [11:0] ctl(input logic [1:0] pm,
    input logic [2:0] ad, input logic [1:0] md, input logic [3:0] low);
    return {1'b0, pm, ad, md, low};
  endfunction

  // next eligible channel above c, wrapping; c = 7 gives the lowest
  function automatic int nxt(input logic [7:0] e, input int c);
    for (int i = 1; i <= 8; i++)
      if (e[(c + i) % 8])
        return (c + i) % 8;
    return c;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wctl(input logic [11:0] w);
    acs_host_inst.write_word(w);
    tc = w[0];
    chk({span_double, twos_complement, power_mode}, {w[1], w[0], w[10:9]});
  endtask

  task automatic conv(input int ch);
    logic [11:0] v;
    v = 12'(xs());
    exp_q.push_back({1'b0, 3'(ch), tc ? v ^ ACS_SAR_MSB : v});
    acs_host_inst.convert(13, v);
  endtask

  task automatic step(input logic [7:0] e, input int n);
    repeat (n)
    begin
      cur = nxt(e, cur);
      conv(cur);
    end
  endtask

  task automatic run_mask(input logic [1:0] md, input logic [7:0] m,
    input logic [7:0] e, input int n);
    wctl(ctl(2'h0, 3'h0, md, 4'b0100));
    acs_host_inst.write_word({4'h0, m});
    cur = 7;
    step(e, n);
  endtask

  // ---------------------------------------------------------------
  // result monitor
  // ---------------------------------------------------------------
  always @(negedge core_clk)
  begin
    if (conv_aborted === 1'b1)
      n_abort++;
    if (conv_done === 1'b1)
      chk({1'b0, vin_plus_sel, conv_result},
          exp_q.size() ? exp_q.pop_front() : 16'hffff);
  end

  initial
  begin
    #150000;
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({vin_minus_gnd, power_mode, span_double, twos_complement}, 16'h0010);
    for (int i = 0; i < 8; i++)
    begin
      wctl(ctl(2'h0, 3'(i), 2'h0, {2'b00, 2'(xs())}));
      conv(i);
    end
    // stop mid-run so a lost position would show after the keep write
    run_mask(2'h0, 8'ha4, 8'ha4, 2);
    wctl(ctl(2'h1, 3'h0, 2'h0, 4'b1001));
    step(8'ha4, 2);
    wctl(ctl(2'h0, 3'h3, 2'h0, 4'b0000));
    conv(3);
    run_mask(2'h1, 8'hff, 8'h55, 5);
    run_mask(2'h2, 8'h3c, 8'h14, 3);
    run_mask(2'h3, 8'hff, 8'h7f, 8);
    wctl(ctl(2'h2, 3'h2, 2'h0, 4'b1100));
    cur = 7;
    step(8'h07, 4);
    wctl(ctl(2'h0, 3'h5, 2'h0, 4'b0000));
    acs_host_inst.convert(5, 12'h0ff);
    conv(5);
    chk(16'(n_abort), 16'h0001);
    wctl(ctl(2'h3, 3'h5, 2'h0, 4'b0000));
    acs_host_inst.convert(2, 12'h123);
    chk({track_hold, power_down}, 16'h0001);
    chk(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire
